// [verilog/mcz_defines.svh]
/*
 * Constants for the meter conversion and zero controller: register
 * offsets, field positions, the zero error code, limits and timing figures.
 * Assumes it is included by bare name after the package.
 */
`ifndef MCZ_DEFINES_SVH
`define MCZ_DEFINES_SVH
`define MCZ_CLK_MHZ      200
`define MCZ_INTEG_MS     160
`define MCZ_CLEAR_CYC    16
`define MCZ_AVG_N        4
`define MCZ_AVG_SHIFT    2
`define MCZ_ERR_ZERO     4'h4
`define MCZ_LIM_NUM      15
`define MCZ_LIM_DEN      1000
`define MCZ_A_CTRL       8'h00
`define MCZ_A_STAT       8'h04
`define MCZ_A_RESULT     8'h08
`define MCZ_A_IRQ_STAT   8'h0C
`define MCZ_A_IRQ_CLR    8'h10
`define MCZ_A_IRQ_EN     8'h14
`define MCZ_CTRL_RANGE   2:0
`define MCZ_CTRL_AUTO    3
`define MCZ_CTRL_ZERO    4
`define MCZ_EV_RESULT    0
`define MCZ_EV_ZDONE     1
`define MCZ_EV_ZERR      2
`endif

// [verilog/mcz_pkg.sv]
/*
 * Types shared by the meter conversion and zero controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package mcz_pkg;
    // Gray order along clear, integrate, discharge, done.
    typedef enum logic [1:0] {
        MCZ_ST_CLEAR = 2'b00,
        MCZ_ST_INTEG = 2'b01,
        MCZ_ST_DEINT = 2'b11,
        MCZ_ST_DONE  = 2'b10
    } mcz_state_t;
    typedef enum logic [1:0] {
        MCZ_FN_DCV  = 2'h0,
        MCZ_FN_ACV  = 2'h1,
        MCZ_FN_OHM  = 2'h2,
        MCZ_FN_TEMP = 2'h3
    } mcz_func_t;
    typedef enum logic [1:0] {
        MCZ_ACF_NONE = 2'h0,
        MCZ_ACF_10HZ = 2'h1,
        MCZ_ACF_1HZ  = 2'h2,
        MCZ_ACF_P1HZ = 2'h3
    } mcz_acf_t;
endpackage
`default_nettype wire

// [verilog/mcz_top.sv]
/*
 * Conversion sequencer, function and filter selection, per-range zero
 * capture and block averaging for a precision meter.
 * Assumes all inputs are synchronous to CORE_CLK, keys arrive as
 * one-cycle pulses and the null detector is debounced outside.
 */
`default_nettype none
`include "mcz_defines.svh"
module mcz_top
    import mcz_pkg::*;
#(
    parameter int DW     = 24,
    parameter int RW     = 3,
    parameter int CW     = 26,
    parameter int INTEG_CYC = `MCZ_INTEG_MS * `MCZ_CLK_MHZ * 1000,
    parameter int FULL_SCALE = 2000000,
    parameter int TOP_RANGE  = 7
) (
    input  wire logic          CORE_CLK,   // 200 MHz clock
    input  wire logic          RESETN,     // synchronous reset
    input  wire logic          CE,         // freezes all state when low
    input  wire logic [7:0]    ADDR,       // register byte address
    input  wire logic [31:0]   WDATA,      // register write data
    input  wire logic          WR,         // write strobe
    input  wire logic          RD,         // read strobe
    output logic      [31:0]   RDATA,      // read data, cycle after RD
    output logic               IRQ,        // level interrupt
    input  wire logic          NULL_DET,   // integrator back at zero
    input  wire logic          INPUT_NEG,  // input polarity negative
    output logic               INTEG_CLR,  // shorts the integrator
    output logic               INTEG_IN,   // connects the input
    output logic               REF_POS,    // positive reference on
    output logic               REF_NEG,    // negative reference on
    output logic      [RW-1:0] RANGE_SEL,  // range to analog front end
    input  wire logic [3:0]    KEY_FUNC,   // temp, kohm, ac, dc pulses
    output logic      [3:0]    FUNC_LAMP,  // one lamp per function
    input  wire logic          KEY_ZERO,   // zero key pulse
    input  wire logic          KEY_FILTER, // filter key toggles mode
    input  wire logic [2:0]    KEY_ACF,    // 10, 1, 0.1 Hz keys
    output logic      [1:0]    ACF_SEL,    // selected AC filter
    output logic               FILTER_ON,  // filter mode lamp
    output logic      [DW-1:0] RESULT,     // corrected reading
    output logic               RESULT_VLD, // one pulse per reading
    output logic      [3:0]    ERR_CODE,   // displayed error number
    output logic               NV_WE,      // offset store pulse
    output logic      [RW-1:0] NV_ADDR,    // offset store range
    output logic      [DW-1:0] NV_DATA     // offset store value
);
    localparam int NR = 1 << RW;
    localparam int LIMIT = FULL_SCALE * `MCZ_LIM_NUM / `MCZ_LIM_DEN;
    localparam logic [DW-1:0] LIM_V = DW'(LIMIT);
    localparam logic [RW-1:0] TOP_R = RW'(TOP_RANGE);
    mcz_state_t       st_q;
    logic [CW-1:0]    cnt_q;
    mcz_func_t        func_q;
    mcz_acf_t         acf_q;
    logic [RW-1:0]    rng_q, save_q;
    logic             pol_q, filt_q, auto_q, zpend_q, sweep_q;
    logic signed [DW-1:0] off_q [NR];
    logic signed [DW+1:0] acc_q;
    logic [1:0]       nacc_q;
    logic [2:0]       ist_q, ien_q;
    logic signed [DW-1:0] raw, corr, mag;
    logic             conv_done, zero_req, zero_ok, avg_on, wr_ctrl;
    // ************************************************************
    // Conversion sequencer
    // ************************************************************
    assign conv_done = CE && st_q == MCZ_ST_DONE;
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            st_q  <= MCZ_ST_CLEAR;
            cnt_q <= '0;
            pol_q <= 1'b0;
        end else if (CE) begin
            case (st_q)
                MCZ_ST_CLEAR: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == CW'(`MCZ_CLEAR_CYC - 1)) begin
                        st_q  <= MCZ_ST_INTEG;
                        cnt_q <= '0;
                    end
                end
                MCZ_ST_INTEG: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == CW'(INTEG_CYC - 1)) begin
                        st_q  <= MCZ_ST_DEINT;
                        pol_q <= INPUT_NEG;
                        cnt_q <= '0;
                    end
                end
                MCZ_ST_DEINT: begin
                    // The count saturates so a dead detector still ends.
                    if (NULL_DET || &cnt_q) begin
                        st_q <= MCZ_ST_DONE;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                MCZ_ST_DONE: begin
                    st_q  <= MCZ_ST_CLEAR;
                    cnt_q <= '0;
                end
                default: st_q <= MCZ_ST_CLEAR;
            endcase
        end
    end
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            INTEG_CLR <= 1'b1;
            INTEG_IN  <= 1'b0;
            REF_POS   <= 1'b0;
            REF_NEG   <= 1'b0;
        end else if (CE) begin
            INTEG_CLR <= (st_q == MCZ_ST_DONE) ||
                         (st_q == MCZ_ST_CLEAR &&
                          cnt_q != CW'(`MCZ_CLEAR_CYC - 1));
            INTEG_IN  <= (st_q == MCZ_ST_CLEAR &&
                          cnt_q == CW'(`MCZ_CLEAR_CYC - 1)) ||
                         (st_q == MCZ_ST_INTEG &&
                          cnt_q != CW'(INTEG_CYC - 1));
            REF_POS <= (st_q == MCZ_ST_INTEG &&
                        cnt_q == CW'(INTEG_CYC - 1) && INPUT_NEG) ||
                       (st_q == MCZ_ST_DEINT && !NULL_DET &&
                        !(&cnt_q) && pol_q);
            REF_NEG <= (st_q == MCZ_ST_INTEG &&
                        cnt_q == CW'(INTEG_CYC - 1) && !INPUT_NEG) ||
                       (st_q == MCZ_ST_DEINT && !NULL_DET &&
                        !(&cnt_q) && !pol_q);
        end
    end
    // ************************************************************
    // Reading and correction
    // ************************************************************
    always_comb begin
        raw  = pol_q ? -DW'(cnt_q) : DW'(cnt_q);
        corr = raw - off_q[rng_q];
        mag  = raw[DW-1] ? -raw : raw;
    end
    assign zero_ok = !mag[DW-1] && mag <= LIM_V;
    assign avg_on  = filt_q && func_q != MCZ_FN_ACV;
    // ************************************************************
    // Function, range and filter selection
    // ************************************************************
    assign wr_ctrl  = CE && WR && ADDR == `MCZ_A_CTRL;
    assign zero_req = CE && !zpend_q &&
                      (func_q == MCZ_FN_DCV || func_q == MCZ_FN_OHM) &&
                      (KEY_ZERO || (wr_ctrl && WDATA[`MCZ_CTRL_ZERO]));
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            func_q <= MCZ_FN_DCV;
        end else if (CE && !zpend_q) begin
            if (KEY_FUNC[3]) func_q <= MCZ_FN_DCV;
            else if (KEY_FUNC[2]) func_q <= MCZ_FN_ACV;
            else if (KEY_FUNC[1]) func_q <= MCZ_FN_OHM;
            else if (KEY_FUNC[0]) func_q <= MCZ_FN_TEMP;
        end
    end
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            acf_q  <= MCZ_ACF_NONE;
            filt_q <= 1'b0;
        end else if (CE) begin
            if (KEY_FILTER) filt_q <= !filt_q;
            if (KEY_ACF[0]) acf_q <= MCZ_ACF_10HZ;
            else if (KEY_ACF[1]) acf_q <= MCZ_ACF_1HZ;
            else if (KEY_ACF[2]) acf_q <= MCZ_ACF_P1HZ;
        end
    end
    // Range writes are dropped while a zero is pending so a capture cannot
    // land on the wrong range.
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            rng_q   <= TOP_R;
            save_q  <= TOP_R;
            auto_q  <= 1'b0;
            zpend_q <= 1'b0;
            sweep_q <= 1'b0;
        end else if (CE) begin
            if (wr_ctrl && !zpend_q) begin
                rng_q  <= WDATA[`MCZ_CTRL_RANGE];
                auto_q <= WDATA[`MCZ_CTRL_AUTO];
            end
            if (zero_req) begin
                zpend_q <= 1'b1;
                if (auto_q) begin
                    sweep_q <= 1'b1;
                    save_q  <= rng_q;
                    rng_q   <= '0;
                end
            end else if (zpend_q && conv_done) begin
                if (sweep_q && rng_q != RW'(NR - 1)) begin
                    rng_q <= rng_q + 1'b1;
                end else begin
                    zpend_q <= 1'b0;
                    sweep_q <= 1'b0;
                    if (sweep_q) rng_q <= save_q;
                end
            end
        end
    end
    // ************************************************************
    // Offset store
    // ************************************************************
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            for (int i = 0; i < NR; i++) off_q[i] <= '0;
        end else if (CE && zpend_q && conv_done && zero_ok) begin
            off_q[rng_q] <= raw;
        end
    end
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            NV_WE    <= 1'b0;
            NV_ADDR  <= '0;
            NV_DATA  <= '0;
            ERR_CODE <= '0;
        end else if (CE) begin
            NV_WE <= zpend_q && conv_done && zero_ok;
            if (zpend_q && conv_done) begin
                NV_ADDR <= rng_q;
                NV_DATA <= raw;
                if (!zero_ok) ERR_CODE <= `MCZ_ERR_ZERO;
            end else if (zero_req) begin
                ERR_CODE <= '0;
            end
        end
    end
    // ************************************************************
    // Block averaging and result
    // ************************************************************
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            acc_q      <= '0;
            nacc_q     <= '0;
            RESULT     <= '0;
            RESULT_VLD <= 1'b0;
        end else if (CE) begin
            RESULT_VLD <= 1'b0;
            if (conv_done && !zpend_q) begin
                if (!avg_on) begin
                    RESULT     <= corr;
                    RESULT_VLD <= 1'b1;
                    nacc_q     <= '0;
                    acc_q      <= '0;
                end else if (nacc_q == 2'(`MCZ_AVG_N - 1)) begin
                    RESULT <= DW'((acc_q + (DW+2)'(corr))
                                  >>> `MCZ_AVG_SHIFT);
                    RESULT_VLD <= 1'b1;
                    nacc_q     <= '0;
                    acc_q      <= '0;
                end else begin
                    acc_q  <= acc_q + (DW+2)'(corr);
                    nacc_q <= nacc_q + 1'b1;
                end
            end
        end
    end
    // ************************************************************
    // Registers and interrupt
    // ************************************************************
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            ist_q <= '0;
            ien_q <= '0;
        end else if (CE) begin
            // A new event wins over a clear in the same cycle.
            ist_q <= (ist_q & ~((WR && ADDR == `MCZ_A_IRQ_CLR) ?
                                WDATA[2:0] : 3'h0)) |
                     {zpend_q && conv_done && !zero_ok,
                      zpend_q && conv_done &&
                      (!sweep_q || rng_q == RW'(NR - 1)),
                      conv_done && !zpend_q};
            if (WR && ADDR == `MCZ_A_IRQ_EN) ien_q <= WDATA[2:0];
        end
    end
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            RDATA <= '0;
        end else if (CE) begin
            RDATA <= '0;
            if (RD) begin
                case (ADDR)
                    `MCZ_A_CTRL:     RDATA <= {28'h0, auto_q, rng_q};
                    `MCZ_A_STAT:     RDATA <= {24'h0, zpend_q, filt_q,
                                               acf_q, func_q, st_q};
                    `MCZ_A_RESULT:   RDATA <= 32'(signed'(RESULT));
                    `MCZ_A_IRQ_STAT: RDATA <= {29'h0, ist_q};
                    `MCZ_A_IRQ_EN:   RDATA <= {29'h0, ien_q};
                    default:         RDATA <= '0;
                endcase
            end
        end
    end
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            IRQ       <= 1'b0;
            FUNC_LAMP <= 4'h8;
            RANGE_SEL <= TOP_R;
            ACF_SEL   <= '0;
            FILTER_ON <= 1'b0;
        end else if (CE) begin
            IRQ       <= |(ist_q & ien_q);
            FUNC_LAMP <= 4'h1 << (2'h3 - func_q);
            RANGE_SEL <= rng_q;
            ACF_SEL   <= acf_q;
            FILTER_ON <= filt_q;
        end
    end
    // ************************************************************
    // Checks
    // ************************************************************
    a_clear_before_integ: assert property (@(posedge CORE_CLK)
        disable iff (!RESETN || !CE) $rose(INTEG_IN) |-> $past(INTEG_CLR))
        else $error("integration began without a cleared integrator");
    a_integ_length: assert property (@(posedge CORE_CLK)
        disable iff (!RESETN || !CE)
        (st_q == MCZ_ST_INTEG && cnt_q == CW'(INTEG_CYC - 1))
        |=> st_q == MCZ_ST_DEINT && cnt_q == '0)
        else $error("integration period wrong");
    a_ref_opposite: assert property (@(posedge CORE_CLK)
        disable iff (!RESETN || !CE)
        (REF_POS |-> pol_q && !REF_NEG) and (REF_NEG |-> !pol_q))
        else $error("reference polarity not opposite to input");
    a_power_up: assert property (@(posedge CORE_CLK)
        $rose(RESETN) |-> func_q == MCZ_FN_DCV && rng_q == TOP_R)
        else $error("power up setting is not DC top range");
    a_one_lamp: assert property (@(posedge CORE_CLK)
        disable iff (!RESETN || !CE) ##1 $onehot(FUNC_LAMP))
        else $error("function lamps not one hot");
    a_zero_funcs: assert property (@(posedge CORE_CLK)
        disable iff (!RESETN || !CE)
        $rose(zpend_q) |-> func_q == MCZ_FN_DCV || func_q == MCZ_FN_OHM)
        else $error("zero started on a wrong function");
    a_store_limit: assert property (@(posedge CORE_CLK)
        disable iff (!RESETN || !CE)
        NV_WE |-> (NV_DATA[DW-1] ? -NV_DATA : NV_DATA) <= LIM_V
                  && off_q[NV_ADDR] == NV_DATA)
        else $error("stored offset beyond limit or not kept");
    a_error_four: assert property (@(posedge CORE_CLK)
        disable iff (!RESETN || !CE)
        (zpend_q && conv_done && !zero_ok)
        |=> ERR_CODE == `MCZ_ERR_ZERO && !NV_WE)
        else $error("oversize offset not reported");
    a_sweep_up: assert property (@(posedge CORE_CLK)
        disable iff (!RESETN || !CE)
        (sweep_q && conv_done && rng_q != RW'(NR - 1))
        |=> rng_q == $past(rng_q) + 1'b1)
        else $error("zero sweep did not step upward");
endmodule
`default_nettype wire

// [verification/mcz_analog_model.sv]
/*
 * Behavioural integrator, reference switch and null detector facing the
 * meter controller, with counters of sequencing faults for the bench.
 * Assumes one clock shared with the controller and a bench that changes
 * the input level and polarity only between conversions.
 */
`default_nettype none
module mcz_analog_model (
    input  wire logic        clk,       // core clock
    input  wire logic        integ_clr, // integrator short
    input  wire logic        integ_in,  // input connected
    input  wire logic        ref_pos,   // positive reference on
    input  wire logic        ref_neg,   // negative reference on
    input  wire logic [31:0] dly,       // discharge length in cycles
    input  wire logic        neg,       // input polarity negative
    output logic             null_det,  // integrator at zero
    output logic             input_neg, // polarity to controller
    output int               nulls,     // discharges ended at zero
    output int               bad,       // sequencing faults seen
    output int               integ_len  // last integrate length
);
    timeunit 1ns;
    timeprecision 1ps;
    int   cnt_q;
    int   run_q;
    logic clr_seen_q;
    initial begin
        null_det = 1'b1;
        nulls = 0;
        bad = 0;
        integ_len = 0;
        cnt_q = 0;
        run_q = 0;
        clr_seen_q = 1'b0;
    end
    assign input_neg = neg;
    // The detector rises once dly reference cycles have passed, and reads high
    // whenever neither the input nor a reference is on, whether or not the charge is gone.
    always @(posedge clk) begin
        if (integ_in) begin
            if ((run_q == 0 && !clr_seen_q) || integ_clr)
                bad <= bad + 1;
            run_q <= run_q + 1;
            clr_seen_q <= 1'b0;
            null_det <= 1'b0;
        end else begin
            if (run_q != 0)
                integ_len <= run_q;
            run_q <= 0;
            if (integ_clr)
                clr_seen_q <= 1'b1;
            if (ref_pos || ref_neg) begin
                if ((ref_pos && !neg) || (ref_neg && neg) ||
                    (ref_pos && ref_neg))
                    bad <= bad + 1;
                cnt_q <= cnt_q + 1;
                null_det <= (cnt_q + 1 >= int'(dly));
                if (cnt_q + 1 == int'(dly))
                    nulls <= nulls + 1;
            end else begin
                cnt_q <= 0;
                null_det <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [verification/tb_meter_conversion_zero_control.sv]
/*
 * Self-checking bench for the meter conversion and zero controller.
 * Assumes the analog model stands on the far side and that readings are
 * judged against zeroed ranges, while stored offsets must equal the model's dly count, negated for a negative input.
 */
`default_nettype none
`include "mcz_defines.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
    err_count++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_meter_conversion_zero_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int INTEG = 100;
    localparam int FS    = 200000;
    logic        CORE_CLK, RESETN, WR, RD, IRQ, NULL_DET, INPUT_NEG;
    logic        INTEG_CLR, INTEG_IN, REF_POS, REF_NEG, FILTER_ON;
    logic        RESULT_VLD, NV_WE, neg, ce;
    logic [7:0]  ADDR;
    logic [31:0] WDATA, RDATA, seed, dly;
    logic [8:0]  kv;
    logic [2:0]  RANGE_SEL, NV_ADDR;
    logic [3:0]  FUNC_LAMP, ERR_CODE;
    logic [1:0]  ACF_SEL;
    logic [23:0] RESULT, NV_DATA, e_t;
    logic [23:0] expq[$];
    logic [2:0]  nvq[$];
    logic [23:0] nvdq[$];
    int          err_count, checked, cyc, nulls, bad, integ_len;

    mcz_top #(.INTEG_CYC(INTEG), .FULL_SCALE(FS)) dut (
        .CORE_CLK(CORE_CLK), .RESETN(RESETN), .CE(ce), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ),
        .NULL_DET(NULL_DET), .INPUT_NEG(INPUT_NEG), .INTEG_CLR(INTEG_CLR),
        .INTEG_IN(INTEG_IN), .REF_POS(REF_POS), .REF_NEG(REF_NEG),
        .RANGE_SEL(RANGE_SEL), .KEY_FUNC(kv[3:0]), .FUNC_LAMP(FUNC_LAMP),
        .KEY_ZERO(kv[4]), .KEY_FILTER(kv[5]), .KEY_ACF(kv[8:6]),
        .ACF_SEL(ACF_SEL), .FILTER_ON(FILTER_ON), .RESULT(RESULT),
        .RESULT_VLD(RESULT_VLD), .ERR_CODE(ERR_CODE), .NV_WE(NV_WE),
        .NV_ADDR(NV_ADDR), .NV_DATA(NV_DATA));
    mcz_analog_model model (
        .clk(CORE_CLK), .integ_clr(INTEG_CLR), .integ_in(INTEG_IN),
        .ref_pos(REF_POS), .ref_neg(REF_NEG), .dly(dly), .neg(neg),
        .null_det(NULL_DET), .input_neg(INPUT_NEG), .nulls(nulls),
        .bad(bad), .integ_len(integ_len));

    initial begin
        CORE_CLK = 1'b0;
        forever #2.5 CORE_CLK = ~CORE_CLK;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic close_out();
        if (err_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CORE_CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CORE_CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge CORE_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CORE_CLK);
        RD <= 1'b0;
        @(negedge CORE_CLK);
        d = RDATA;
    endtask
    task automatic press(input logic [8:0] v);
        @(posedge CORE_CLK);
        kv <= v;
        @(posedge CORE_CLK);
        kv <= 9'h000;
        // Lamps and selections are registered once more after the key.
        @(posedge CORE_CLK);
        @(negedge CORE_CLK);
    endtask
    // New input takes effect from the conversion already in its clear phase.
    task automatic set_in(input int d, input logic n);
        @(negedge CORE_CLK iff RESULT_VLD === 1'b1);
        @(posedge CORE_CLK);
        dly <= 32'(d);
        neg <= n;
    endtask
    task automatic expect_val(input logic [23:0] v);
        @(posedge CORE_CLK);
        expq.push_back(v);
        wait (expq.size() == 0);
    endtask
    task automatic zero(input logic [2:0] rng, input logic [23:0] ofs);
        nvq.delete();
        nvdq.delete();
        press(9'h010);
        wait (nvq.size() == 1);
        `CHK("nv_addr", rng, nvq[0])
        `CHK("nv_data", ofs, nvdq[0])
        expect_val(24'h000000);
    endtask

    always @(negedge CORE_CLK) begin
        if (RESULT_VLD === 1'b1 && expq.size() > 0) begin
            e_t = expq.pop_front();
            `CHK("result", e_t, RESULT)
        end
        if (NV_WE === 1'b1) begin
            nvdq.push_back(NV_DATA);
            nvq.push_back(NV_ADDR);
        end
    end
    always @(posedge CORE_CLK) begin
        cyc++;
        if (cyc == 90000) begin
            err_count++;
            close_out();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        int          d0, dd, n0;
        logic [31:0] r;
        RESETN = 1'b0; WR = 1'b0; RD = 1'b0; ADDR = 8'h00; WDATA = 32'h0;
        kv = 9'h000; dly = 32'd500; neg = 1'b0; seed = 32'd23881;
        err_count = 0; checked = 0; cyc = 0;
        ce = 1'b1;
        repeat (3) @(posedge CORE_CLK);
        RESETN <= 1'b1;
        @(negedge CORE_CLK);
        `CHK("lamp", 4'h8, FUNC_LAMP)
        `CHK("range", 3'h7, RANGE_SEL)
        wr(8'h20, xs());
        rd(8'h20, r);
        `CHK("unmapped", 32'h0, r)
        wr(`MCZ_A_CTRL, 32'h3);
        rd(`MCZ_A_CTRL, r);
        `CHK("ctrl", 5'h03, r[4:0])
        `CHK("range", 3'h3, RANGE_SEL)
        wr(`MCZ_A_IRQ_EN, 32'h1);
        set_in(500, 1'b0);
        repeat (2) @(negedge CORE_CLK);
        `CHK("irq", 1'b1, IRQ)
        rd(`MCZ_A_IRQ_STAT, r);
        `CHK("irq_stat", 1'b1, r[0])
        wr(`MCZ_A_IRQ_EN, 32'h0);
        repeat (2) @(negedge CORE_CLK);
        `CHK("irq", 1'b0, IRQ)
        set_in(500, 1'b0);
        wr(`MCZ_A_IRQ_CLR, 32'h7);
        rd(`MCZ_A_IRQ_STAT, r);
        `CHK("irq_stat", 3'h0, r[2:0])
        for (int i = 0; i < 4; i++) begin
            press(9'(4'h1 << i));
            `CHK("lamp", 4'(4'h1 << i), FUNC_LAMP)
            if (i == 2) begin
                press(9'h010);
                rd(`MCZ_A_STAT, r);
                `CHK("pending", 1'b0, r[7])
            end
        end
        for (int i = 0; i < 3; i++) begin
            press(9'(9'h040 << i));
            `CHK("acf", 2'(i + 1), ACF_SEL)
        end
        d0 = 300 + int'(xs() % 200);
        dd = 1 + int'(xs() % 100);
        set_in(d0, 1'b0);
        zero(3'h3, 24'(d0));
        `CHK("err", 4'h0, ERR_CODE)
        set_in(d0 + dd, 1'b0);
        expect_val(24'(dd));
        set_in(d0, 1'b1);
        zero(3'h3, 24'(-d0));
        set_in(d0 + dd, 1'b1);
        expect_val(24'(-dd));
        wr(`MCZ_A_CTRL, 32'h2);
        set_in(d0 + 50, 1'b0);
        zero(3'h2, 24'(d0 + 50));
        wr(`MCZ_A_CTRL, 32'h3);
        set_in(d0 + dd, 1'b1);
        expect_val(24'(-dd));
        nvq.delete();
        set_in(4000, 1'b0);
        press(9'h010);
        wait (ERR_CODE === `MCZ_ERR_ZERO);
        `CHK("nv_writes", 0, nvq.size())
        set_in(d0 + dd, 1'b1);
        expect_val(24'(-dd));
        press(9'h020);
        `CHK("filter", 1'b1, FILTER_ON)
        set_in(d0 + dd, 1'b1);
        n0 = nulls;
        expect_val(24'(-dd));
        `CHK("block", 4, nulls - n0)
        press(9'h020);
        wr(`MCZ_A_CTRL, 32'hB);
        nvq.delete();
        nvdq.delete();
        press(9'h010);
        wait (nvq.size() == 8);
        for (int i = 0; i < 8; i++) begin
            `CHK("sweep", 3'(i), nvq[i])
            `CHK("sweep_data", 24'(-(d0 + dd)), nvdq[i])
        end
        `CHK("err", 4'h0, ERR_CODE)
        `CHK("faults", 0, bad)
        `CHK("integ", INTEG, integ_len)
        // With the clock enable low a function key must change nothing.
        @(posedge CORE_CLK);
        ce <= 1'b0;
        press(9'h004);
        `CHK("frozen", 4'h8, FUNC_LAMP)
        close_out();
    end
endmodule
`default_nettype wire
